/* core/flash_protect_pkg.sv */
// Types shared by the sector protection command block
package flash_protect_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_FINISH = 2'b11
  } run_state_t;

  typedef enum logic [2:0] {
    JOB_NONE = 3'h0,
    JOB_NV_PROG = 3'h1,
    JOB_NV_ERASE = 3'h2,
    JOB_MODE_PROG = 3'h3,
    JOB_LOCK_CLEAR = 3'h4
  } job_t;

endpackage : flash_protect_pkg

/* core/flash_protect_regs.svh */
// Opcodes, field sizes, reset values and timing figures for the sector protection command block
`ifndef FLASH_PROTECT_REGS_SVH
`define FLASH_PROTECT_REGS_SVH

`define OP_WRITE_ENABLE 8'h06
`define OP_VOL_WRITE 8'hfb
`define OP_VOL_WRITE_WIDE 8'he1
`define OP_NV_READ 8'hfc
`define OP_NV_READ_WIDE 8'he2
`define OP_NV_PROG 8'hfd
`define OP_NV_PROG_WIDE 8'he3
`define OP_NV_ERASE 8'he4
`define OP_MODE_READ 8'h2b
`define OP_MODE_PROG 8'h2f
`define OP_LOCK_READ 8'ha7
`define OP_LOCK_CLEAR 8'ha6

`define PROTECTED_BYTE 8'h00
`define UNPROTECTED_BYTE 8'hff

`define OPCODE_BITS 7'h08
`define ADDR3_BITS 7'h18
`define ADDR4_BITS 7'h20
`define DATA_BITS 7'h08
`define MODE_BITS 7'h10
`define NO_START 7'h7f

`define MODE_REG_RESET 16'hffff
`define LOCK_BIT_RESET 1'h1
`define LOCK_BIT_POS 0

`define REF_CLK_MHZ 100
`define NV_PROG_TIME_US 100
`define NV_ERASE_TIME_US 50000
`define MODE_PROG_TIME_US 100
`define LOCK_CLEAR_TIME_US 50

`endif

/* core/flash_sector_protect_cmds.sv */
// Serial command handling for volatile and non-volatile sector protection, mode register and lock bit
`timescale 1ns/1ps
`include "flash_protect_regs.svh"

// Operation
// - Volatile protect write needs the write enable latch set beforehand.
// - FBh takes 3 or 4 address bytes by extended flag; E1h always 4.
// - Volatile write takes one data byte; update starts when chip select rises.
// - FCh/E2h read: opcode and address sampled, then protect byte shifted out.
// - Non-volatile protect read is served only in single-line mode, not QPI.
// - Protect byte repeats every eight clocks; address never increments.
// - FDh/E3h program has no data; chip select rises after address.
// - Program holds write-in-progress high, then clears it and the latch.
// - E4h erases whole non-volatile array to ones, busy throughout, latch cleared.
// - Erase starts only when chip select rises right after eighth bit.
// - Erase suspend is refused while the protect array erase runs.
// - 2Bh shifts out 16-bit mode register, low byte first, MSB first.
// - Mode register contents repeat every sixteen clocks while selected.
// - Mode program runs only if chip select rises after sixteenth data bit.
// - Mode program shows busy until done, then clears the latch.
// - A7h returns lock register every eight clocks, only when idle.
// - A6h after write enable clears the lock bit.
// - Lock clear needs exact eight bits; busy while running, latch cleared after.
// - Extended flag selects 24-bit or 32-bit addresses for three-byte opcodes.
module flash_sector_protect_cmds
  import flash_protect_pkg::*;
#(
  parameter int unsigned SECTOR_COUNT = 512,
  parameter int unsigned SECTOR_SHIFT = 16,
  parameter int unsigned NV_PROG_CYCLES = `NV_PROG_TIME_US * `REF_CLK_MHZ,
  parameter int unsigned NV_ERASE_CYCLES = `NV_ERASE_TIME_US * `REF_CLK_MHZ,
  parameter int unsigned MODE_PROG_CYCLES = `MODE_PROG_TIME_US * `REF_CLK_MHZ,
  parameter int unsigned LOCK_CLEAR_CYCLES = `LOCK_CLEAR_TIME_US * `REF_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic sclk,
  input wire logic chipSelN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEnN,
  input wire logic qpiMode,
  input wire logic extendedAddressFlag,
  output logic writeEnableLatch,
  output logic writeInProgress,
  output logic eraseSuspendAllowed,
  output logic [SECTOR_COUNT-1:0] volatileProtect,
  output logic [SECTOR_COUNT-1:0] nvProtect,
  output logic [15:0] protectMode,
  output logic nvProtectLock
);

  localparam int SECTOR_W = $clog2(SECTOR_COUNT);
  function automatic logic [SECTOR_W-1:0] sectorOf(input logic [31:0] addr, input logic wide);
    logic [31:0] full;
    full = wide ? addr : {8'h00, addr[23:0]};
    return full[SECTOR_SHIFT +: SECTOR_W];
  endfunction : sectorOf

  function automatic logic isWideOp(input logic [7:0] op);
    return (op == `OP_VOL_WRITE_WIDE) || (op == `OP_NV_READ_WIDE) || (op == `OP_NV_PROG_WIDE);
  endfunction : isWideOp

  // Link side, clocked by the serial clock
  logic linkRst;
  logic frameOn, frameToggle;
  logic [6:0] bitCnt;
  logic [39:0] shiftIn;
  logic [7:0] opcode;
  logic [SECTOR_W-1:0] rdSector;
  logic [3:0] dataPos;
  logic [1:0] extSync, qpiSync, busySync;
  logic [39:0] shiftNext;
  logic linkWide;
  logic [6:0] linkAddrEnd, startBits;
  logic outBit, outOn;
  logic [7:0] nvByte, lockByte;

  // Held for a cycle after the core reset so the link logic is cleared too
  always_ff @(posedge ref_clk) begin
    linkRst <= ~nrst;
  end

  // Level signals from the core side, resynchronised onto the serial clock
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      extSync <= 2'h0;
      qpiSync <= 2'h0;
      busySync <= 2'h0;
    end else begin
      extSync <= {extSync[0], extendedAddressFlag};
      qpiSync <= {qpiSync[0], qpiMode};
      busySync <= {busySync[0], writeInProgress};
    end
  end

  // Cleared whenever chip select is high, so the first edge of a frame is known
  always_ff @(posedge sclk or posedge chipSelN or posedge linkRst) begin
    if (chipSelN || linkRst) begin
      frameOn <= 1'b0;
    end else begin
      frameOn <= 1'b1;
    end
  end

  assign shiftNext = {shiftIn[38:0], serialIn};
  assign linkWide = isWideOp(opcode) || extSync[1];
  assign linkAddrEnd = `OPCODE_BITS + (linkWide ? `ADDR4_BITS : `ADDR3_BITS);

  // Bit counter saturates so an overlong frame never aliases to a legal length
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      bitCnt <= 7'h00;
      frameToggle <= 1'b0;
      shiftIn <= 40'h0;
      opcode <= 8'h00;
      rdSector <= '0;
    end else begin
      shiftIn <= shiftNext;
      if (!frameOn) begin
        bitCnt <= 7'h01;
        frameToggle <= ~frameToggle;
      end else begin
        if (bitCnt != 7'h7f) begin
          bitCnt <= bitCnt + 7'h01;
        end
        if (bitCnt == `OPCODE_BITS - 7'h01) begin
          opcode <= shiftNext[7:0];
        end
        if (bitCnt + 7'h01 == linkAddrEnd) begin
          rdSector <= sectorOf(shiftNext[31:0], linkWide);
        end
      end
    end
  end

  always_comb begin
    startBits = `NO_START;
    case (opcode)
      `OP_NV_READ, `OP_NV_READ_WIDE: startBits = linkAddrEnd;
      `OP_MODE_READ, `OP_LOCK_READ: startBits = `OPCODE_BITS;
      default: startBits = `NO_START;
    endcase
  end

  // Output position wraps, so reads repeat for as long as chip select stays low
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      dataPos <= 4'h0;
    end else if (!frameOn) begin
      dataPos <= 4'h0;
    end else if (bitCnt >= startBits) begin
      dataPos <= dataPos + 4'h1;
    end
  end

  assign nvByte = nvProtect[rdSector] ? `UNPROTECTED_BYTE : `PROTECTED_BYTE;
  assign lockByte = {7'h00, nvProtectLock};

  // Core-side values are only changed between commands, so they are stable here
  always_comb begin
    outBit = 1'b0;
    outOn = 1'b0;
    if (frameOn && bitCnt >= startBits) begin
      case (opcode)
        `OP_NV_READ, `OP_NV_READ_WIDE: begin
          outOn = ~qpiSync[1];
          outBit = nvByte[~dataPos[2:0]];
        end
        `OP_MODE_READ: begin
          outOn = 1'b1;
          outBit = dataPos[3] ? protectMode[{1'b1, ~dataPos[2:0]}] : protectMode[{1'b0, ~dataPos[2:0]}];
        end
        `OP_LOCK_READ: begin
          outOn = ~busySync[1];
          outBit = lockByte[~dataPos[2:0]];
        end
        default: outOn = 1'b0;
      endcase
    end
  end

  // Data leaves on the falling edge and the pin is released when deselected
  always_ff @(negedge sclk or posedge chipSelN or posedge linkRst) begin
    if (chipSelN || linkRst) begin
      serialOut <= 1'b0;
      serialOutEnN <= 1'b1;
    end else begin
      serialOut <= outBit;
      serialOutEnN <= ~outOn;
    end
  end

  // Core side, clocked by ref_clk
  logic [1:0] csSync, togSync;
  logic csLast, togSeen;
  logic frameEnd, accept, startJob;
  logic [SECTOR_W-1:0] progSector, volSector, jobSector;
  run_state_t runState;
  job_t job, newJob;
  logic [31:0] waitCnt, newWait;
  logic [15:0] jobData;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      csSync <= 2'h3;
      csLast <= 1'b1;
      togSync <= 2'h0;
      togSeen <= 1'b0;
    end else if (clkEn) begin
      csSync <= {csSync[0], chipSelN};
      csLast <= csSync[1];
      togSync <= {togSync[0], frameToggle};
      if (frameEnd) begin
        togSeen <= togSync[1];
      end
    end
  end

  // A rising chip select only counts if the frame carried at least one clock
  assign frameEnd = csSync[1] && !csLast && (togSync[1] != togSeen);
  // Address width comes from the opcode and the synchronised flag, static once the serial clock stops
  assign progSector = sectorOf(shiftIn[31:0], linkWide);
  assign volSector = sectorOf(shiftIn[39:8], linkWide);
  assign accept = frameEnd && (runState == ST_IDLE) && writeEnableLatch;

  always_comb begin
    newJob = JOB_NONE;
    newWait = 32'h1;
    if (accept) begin
      case (opcode)
        `OP_NV_PROG, `OP_NV_PROG_WIDE: begin
          if (bitCnt == linkAddrEnd && nvProtectLock) begin
            newJob = JOB_NV_PROG;
            newWait = NV_PROG_CYCLES;
          end
        end
        `OP_NV_ERASE: begin
          if (bitCnt == `OPCODE_BITS && nvProtectLock) begin
            newJob = JOB_NV_ERASE;
            newWait = NV_ERASE_CYCLES;
          end
        end
        `OP_MODE_PROG: begin
          if (bitCnt == `OPCODE_BITS + `MODE_BITS) begin
            newJob = JOB_MODE_PROG;
            newWait = MODE_PROG_CYCLES;
          end
        end
        `OP_LOCK_CLEAR: begin
          if (bitCnt == `OPCODE_BITS) begin
            newJob = JOB_LOCK_CLEAR;
            newWait = LOCK_CLEAR_CYCLES;
          end
        end
        default: newJob = JOB_NONE;
      endcase
    end
  end
  assign startJob = (newJob != JOB_NONE);

  // Timed internal operation with the busy flag tied to its duration
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      runState <= ST_IDLE;
      job <= JOB_NONE;
      waitCnt <= 32'h0;
      jobSector <= '0;
      jobData <= 16'h0000;
      writeInProgress <= 1'b0;
      eraseSuspendAllowed <= 1'b1;
    end else if (clkEn) begin
      case (runState)
        ST_IDLE: begin
          if (startJob) begin
            runState <= ST_BUSY;
            job <= newJob;
            waitCnt <= (newWait == 32'h0) ? 32'h1 : newWait;
            jobSector <= progSector;
            jobData <= {shiftIn[7:0], shiftIn[15:8]};
            writeInProgress <= 1'b1;
            eraseSuspendAllowed <= (newJob != JOB_NV_ERASE);
          end
        end
        ST_BUSY: begin
          if (waitCnt <= 32'h1) begin
            runState <= ST_FINISH;
          end else begin
            waitCnt <= waitCnt - 32'h1;
          end
        end
        ST_FINISH: begin
          runState <= ST_IDLE;
          job <= JOB_NONE;
          writeInProgress <= 1'b0;
          eraseSuspendAllowed <= 1'b1;
        end
        default: begin
          runState <= ST_IDLE;
          job <= JOB_NONE;
          writeInProgress <= 1'b0;
          eraseSuspendAllowed <= 1'b1;
        end
      endcase
    end
  end

  // Latch set by the write enable opcode, cleared when a timed job completes
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      writeEnableLatch <= 1'b0;
    end else if (clkEn) begin
      if (runState == ST_FINISH) begin
        writeEnableLatch <= 1'b0;
      end else if (frameEnd && runState == ST_IDLE && opcode == `OP_WRITE_ENABLE && bitCnt == `OPCODE_BITS) begin
        writeEnableLatch <= 1'b1;
      end
    end
  end

  // Volatile bits update at once on the closing edge of a full-length write
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      volatileProtect <= '1;
    end else if (clkEn) begin
      if (accept && (opcode == `OP_VOL_WRITE || opcode == `OP_VOL_WRITE_WIDE)
          && bitCnt == linkAddrEnd + `DATA_BITS) begin
        volatileProtect[volSector] <= (shiftIn[7:0] != `PROTECTED_BYTE);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      nvProtect <= '1;
    end else if (clkEn && runState == ST_FINISH) begin
      if (job == JOB_NV_PROG) begin
        nvProtect[jobSector] <= 1'b0;
      end else if (job == JOB_NV_ERASE) begin
        nvProtect <= '1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      protectMode <= `MODE_REG_RESET;
    end else if (clkEn && runState == ST_FINISH && job == JOB_MODE_PROG) begin
      protectMode <= jobData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      nvProtectLock <= `LOCK_BIT_RESET;
    end else if (clkEn && runState == ST_FINISH && job == JOB_LOCK_CLEAR) begin
      nvProtectLock <= 1'b0;
    end
  end

endmodule : flash_sector_protect_cmds

/* tb/flash_protect_asserts.sv */
// Concurrent checks on the ports of the sector protection command block
`timescale 1ns/1ps
module flash_protect_asserts #(
  parameter int unsigned SECTOR_COUNT = 512,
  parameter int unsigned NV_ERASE_CYCLES = 5000000
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic chipSelN,
  input wire logic serialOut,
  input wire logic serialOutEnN,
  input wire logic writeEnableLatch,
  input wire logic writeInProgress,
  input wire logic eraseSuspendAllowed,
  input wire logic [SECTOR_COUNT-1:0] volatileProtect,
  input wire logic [SECTOR_COUNT-1:0] nvProtect,
  input wire logic [15:0] protectMode,
  input wire logic nvProtectLock
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [31:0] busyCnt;
  // Longest job is the array erase; slack covers the start delay, frozen cycles are not counted
  always_ff @(posedge ref_clk) begin
    if (!nrst || !writeInProgress) begin
      busyCnt <= 32'h0;
    end else if (clkEn) begin
      busyCnt <= busyCnt + 32'h1;
    end
  end
  property p_busy_bound;
    busyCnt <= NV_ERASE_CYCLES + 8;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
  property p_done_wel;
    $fell(writeInProgress) |-> !writeEnableLatch;
  endproperty
  a_done_wel: assert property (p_done_wel) else $error("latch kept after job");
  property p_job_wel;
    $rose(writeInProgress) |-> writeEnableLatch;
  endproperty
  a_job_wel: assert property (p_job_wel) else $error("job without latch");
  property p_wel_idle;
    $rose(writeEnableLatch) |-> !writeInProgress;
  endproperty
  a_wel_idle: assert property (p_wel_idle) else $error("latch set while busy");
  property p_no_suspend;
    !eraseSuspendAllowed |-> writeInProgress;
  endproperty
  a_no_suspend: assert property (p_no_suspend) else $error("suspend flag off idle");
  property p_lock_one_way;
    !$rose(nvProtectLock);
  endproperty
  a_lock_one_way: assert property (p_lock_one_way) else $error("lock bit set");
  property p_nv_wel;
    $changed(nvProtect) |-> $past(writeEnableLatch);
  endproperty
  a_nv_wel: assert property (p_nv_wel) else $error("nv change no latch");
  property p_mode_wel;
    $changed(protectMode) |-> $past(writeEnableLatch);
  endproperty
  a_mode_wel: assert property (p_mode_wel) else $error("mode change no latch");
  property p_vol_wel;
    $changed(volatileProtect) |-> writeEnableLatch;
  endproperty
  a_vol_wel: assert property (p_vol_wel) else $error("vol change no latch");
  property p_idle_out;
    chipSelN [*2] |-> serialOutEnN && !serialOut;
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("output while idle");
endmodule : flash_protect_asserts

bind flash_sector_protect_cmds flash_protect_asserts #(
  .SECTOR_COUNT(SECTOR_COUNT),
  .NV_ERASE_CYCLES(NV_ERASE_CYCLES)
) i_chk (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .chipSelN(chipSelN), .serialOut(serialOut),
  .serialOutEnN(serialOutEnN), .writeEnableLatch(writeEnableLatch), .writeInProgress(writeInProgress),
  .eraseSuspendAllowed(eraseSuspendAllowed), .volatileProtect(volatileProtect), .nvProtect(nvProtect),
  .protectMode(protectMode), .nvProtectLock(nvProtectLock));

/* tb/spi_host.sv */
// Host serial controller model; its clock runs only inside frames
`timescale 1ns/1ps
module spi_host (
  output logic sclk,
  output logic chipSelN,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEnN
);
  logic lineLvl;
  // Released output line has no pull, so show a level unlike the last driven one
  assign lineLvl = serialOutEnN ? ~serialIn : serialOut;
  initial begin
    sclk = 1'b0;
    chipSelN = 1'b1;
    serialIn = 1'b0;
  end
  task automatic xfer(input logic [47:0] tx, input int n, input int nr, output logic [31:0] rx,
    output logic drove);
    rx = 32'h0;
    drove = 1'b0;
    chipSelN = 1'b0;
    for (int i = 0; i < n; i++) begin
      serialIn = tx[n-1-i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    for (int i = 0; i < nr; i++) begin
      serialIn = ~serialIn;
      #15 sclk = 1'b1;
      rx = {rx[30:0], lineLvl};
      drove = drove | ~serialOutEnN;
      #15 sclk = 1'b0;
    end
    #15 chipSelN = 1'b1;
    serialIn = ~serialIn;
  endtask : xfer
endmodule : spi_host

/* tb/testbench.sv */
// Self-checking bench for the sector protection command block
`timescale 1ns/1ps
`include "flash_protect_regs.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic clkEn = 1'b1;
  logic qpiMode = 1'b0;
  logic extendedAddressFlag = 1'b0;
  logic sclk, chipSelN, serialIn, serialOut, serialOutEnN, write_enable_latch, write_in_progress, esa, lock, drove;
  logic [7:0] vol, nv;
  logic [15:0] mode;
  logic [31:0] rx;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  flash_sector_protect_cmds #(.SECTOR_COUNT(8), .NV_PROG_CYCLES(20), .NV_ERASE_CYCLES(40),
    .MODE_PROG_CYCLES(20), .LOCK_CLEAR_CYCLES(10)) i_dut (.ref_clk(ref_clk),
    .nrst(nrst), .clkEn(clkEn), .sclk(sclk), .chipSelN(chipSelN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEnN(serialOutEnN), .qpiMode(qpiMode),
    .extendedAddressFlag(extendedAddressFlag), .writeEnableLatch(write_enable_latch), .writeInProgress(write_in_progress),
    .eraseSuspendAllowed(esa), .volatileProtect(vol), .nvProtect(nv), .protectMode(mode),
    .nvProtectLock(lock));
  spi_host i_host (.sclk(sclk), .chipSelN(chipSelN), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEnN(serialOutEnN));
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // Six idle cycles cover the chip-select sync and keep the required gap
  task automatic frame(input logic [47:0] tx, input int n, input int nr = 0);
    i_host.xfer(tx, n, nr, rx, drove);
    tick(6);
  endtask : frame
  task automatic wait_idle();
    int k;
    k = 0;
    while (write_in_progress !== 1'b0 && k < 200) begin
      tick(1);
      k++;
    end
    if (k == 200) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_idle
  task automatic t_reset();
    check("wel", write_enable_latch, 1'b0);
    check("wip", write_in_progress, 1'b0);
    check("esa", esa, 1'b1);
    check("vol", vol, 8'hff);
    check("nv", nv, 8'hff);
    check("mode", mode, `MODE_REG_RESET);
    check("lock", lock, 1'b1);
    check("oen", serialOutEnN, 1'b1);
  endtask : t_reset
  task automatic t_volatile();
    frame({`OP_VOL_WRITE, 24'h020000, 8'h00}, 40);
    check("vol", vol, 8'hff);
    frame(`OP_WRITE_ENABLE, 8);
    frame({`OP_VOL_WRITE, 24'h020000, `PROTECTED_BYTE}, 40);
    check("vol", vol, 8'hfb);
    check("wel", write_enable_latch, 1'b1);
    frame({`OP_VOL_WRITE_WIDE, 32'h00050000, `PROTECTED_BYTE}, 48);
    check("vol", vol, 8'hdb);
    extendedAddressFlag = 1'b1;
    frame({`OP_VOL_WRITE, 32'h00030000, `PROTECTED_BYTE}, 48);
    check("vol", vol, 8'hd3);
    extendedAddressFlag = 1'b0;
    frame({`OP_VOL_WRITE, 24'h020000, `UNPROTECTED_BYTE}, 40);
    check("vol", vol, 8'hd7);
    frame({`OP_VOL_WRITE, 24'h000000, 7'h00}, 39);
    check("vol", vol, 8'hd7);
  endtask : t_volatile
  task automatic t_nv();
    frame(`OP_WRITE_ENABLE, 8);
    frame({`OP_NV_PROG, 24'h010000}, 32);
    check("wip", write_in_progress, 1'b1);
    wait_idle();
    check("nv", nv, 8'hfd);
    check("wel", write_enable_latch, 1'b0);
    frame(`OP_WRITE_ENABLE, 8);
    frame({`OP_NV_PROG_WIDE, 32'h00060000}, 40);
    wait_idle();
    check("nv", nv, 8'hbd);
    frame({`OP_NV_READ, 24'h010000}, 32, 16);
    check("nvrd", rx, 32'h0);
    frame({`OP_NV_READ_WIDE, 32'h00000000}, 40, 16);
    check("nvrd", rx, 32'hffff);
    qpiMode = 1'b1;
    frame({`OP_NV_READ, 24'h010000}, 32, 8);
    check("drv", drove, 1'b0);
    qpiMode = 1'b0;
  endtask : t_nv
  task automatic t_erase();
    frame(`OP_WRITE_ENABLE, 8);
    frame({`OP_NV_ERASE, 1'b0}, 9);
    check("wip", write_in_progress, 1'b0);
    frame(`OP_NV_ERASE, 8);
    check("wip", write_in_progress, 1'b1);
    check("esa", esa, 1'b0);
    wait_idle();
    check("nv", nv, 8'hff);
    check("wel", write_enable_latch, 1'b0);
  endtask : t_erase
  // Also holds the clock enable low mid-job: the job must neither finish nor lose its place
  task automatic t_mode();
    frame(`OP_MODE_READ, 8, 32);
    check("mrd", rx, 32'hffffffff);
    frame(`OP_WRITE_ENABLE, 8);
    frame({`OP_MODE_PROG, 15'h1a09}, 23);
    check("mode", mode, 16'hffff);
    frame({`OP_MODE_PROG, 16'h3412}, 24);
    check("wip", write_in_progress, 1'b1);
    clkEn = 1'b0;
    tick(60);
    check("wip", write_in_progress, 1'b1);
    check("mode", mode, 16'hffff);
    clkEn = 1'b1;
    wait_idle();
    check("mode", mode, 16'h1234);
    check("wel", write_enable_latch, 1'b0);
    frame(`OP_MODE_READ, 8, 32);
    check("mrd", rx, 32'h34123412);
  endtask : t_mode
  task automatic t_lock();
    frame(`OP_LOCK_READ, 8, 16);
    check("lrd", rx, 32'h0101);
    frame(`OP_LOCK_CLEAR, 8);
    check("lock", lock, 1'b1);
    frame(`OP_WRITE_ENABLE, 8);
    frame({`OP_LOCK_CLEAR, 1'b0}, 9);
    check("lock", lock, 1'b1);
    frame(`OP_LOCK_CLEAR, 8);
    check("wip", write_in_progress, 1'b1);
    wait_idle();
    check("lock", lock, 1'b0);
    check("wel", write_enable_latch, 1'b0);
    frame(`OP_WRITE_ENABLE, 8);
    frame({`OP_NV_PROG, 24'h040000}, 32);
    check("wip", write_in_progress, 1'b0);
    check("nv", nv, 8'hff);
  endtask : t_lock
  initial begin
    tick(16);
    nrst = 1'b1;
    tick(3);
    t_reset();
    t_volatile();
    t_nv();
    t_erase();
    t_mode();
    t_lock();
    report_and_stop();
  end
endmodule : testbench
